// ### core/bond_clk_pkg.sv
// Purpose: Types of the bonded clock router.
// Assumes: Included with the register header.
// Notes: Reserved mode code behaves as no bonding.
package bond_clk_pkg;
  typedef enum logic [1:0] {BOND_NONE, BOND_X2, BOND_X4, BOND_RSVD} bond_mode_t;
endpackage

// ### core/bond_clk_regs.svh
// Purpose: Register map, field positions and reset values of the bonded clock router.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses.
// Notes: Definitions only.
// How it works
// - Bonded channels share one FIFO pointer set.
// - Bonded low-speed clock from one adjacent PLL.
// - Each channel picks its own high-speed PLL.
// - Large package x2 may use far PLL.
// - Channels 2,3 stay free in x2.
// - Common clock drives encoder, serializer, TX FIFO.
// - Byte serializer halves TX FIFO read clock.
// - Common clock exported as bonded core clock.
// - Receive-only bonding is refused.
// - Bonded receive works with or without rate match.
// - No rate match: receive clocked per channel.
// - Recovered high-speed clock drives deserializer.
// - Recovered low-speed drives aligner, rate match write.
// - Common clock drives rate match read onward.
// - Byte deserializer halves RX FIFO write clock.
// - Per-channel recovered clock drives RX PCS, exported.
`ifndef BOND_CLK_REGS_SVH
`define BOND_CLK_REGS_SVH
`define ADDR_CTRL      4'h0
`define ADDR_CHSEL     4'h4
`define ADDR_STATUS    4'h8
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_BSRC      2
`define CTRL_FAR       3
`define CTRL_BIGPKG    4
`define CTRL_TXEN      5
`define CTRL_RXEN      6
`define CTRL_RMATCH    7
`define CTRL_BSER      8
`define CTRL_BDES      9
`define CTRL_PRST      10
`define CTRL_RESET     11'h000
`define CHSEL_RESET    4'h0
`define ST_REFUSED     2
`define ST_FAR         3
`define ST_WPTR_LO     4
`define ST_RPTR_LO     7
`define NUM_CH         4
`define PTR_W          3
`endif

// ### core/bonded_lane_clock_distribution.sv
// Purpose: Routes PLL and recovered clock ticks to four transceiver channels,
//          with a common bonded low-speed path and shared FIFO pointers.
// Assumes: Every clock is modelled as a one-cycle enable on sys_clk, all
//          inputs come from logic on sys_clk.
// Notes: All routed outputs are registered, so they lag their source by one cycle.
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`include "bond_clk_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bonded_lane_clock_distribution
  import bond_clk_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        pllTickA,
  input  wire logic        pllTickB,
  input  wire logic        pllTickFar,
  input  wire logic [3:0]  cdrHsTick,
  input  wire logic [3:0]  cdrLsTick,
  output logic [3:0]       hsClkEn,
  output logic [3:0]       txPcsEn,
  output logic [3:0]       txFifoRdEn,
  output logic [3:0]       deserEn,
  output logic [3:0]       alignEn,
  output logic [3:0]       rmWrEn,
  output logic [3:0]       rmRdEn,
  output logic [3:0]       rxPcsEn,
  output logic [3:0]       rxFifoWrEn,
  output logic [3:0]       rxClkOut,
  output logic             coreClkOut,
  output logic [11:0]      fifoWrPtr,
  output logic [11:0]      fifoRdPtr
);

  // True when channel ch belongs to the bonded group in mode m.
  function automatic logic inGroup(input bond_mode_t m, input int ch);
    inGroup = (m == BOND_X4) || ((m == BOND_X2) && (ch < 2));
  endfunction

  logic [10:0]  ctrl_q;
  logic [3:0]   chSel_q;
  logic         ack_q;
  logic [31:0]  rdData_q;
  logic         busReq;
  logic         wrTake;
  logic         ptrRst;
  bond_mode_t   reqMode;
  bond_mode_t   mode;
  logic         refused;
  logic         farOk;
  logic         bondLs;
  logic         bondHalf_q;
  logic [2:0]   bondWr_q;
  logic [2:0]   bondRd_q;
  logic         txEn;
  logic         rxEn;
  logic         rmPath;
  logic [3:0]   bondTx;

  // Control fields.
  assign reqMode = bond_mode_t'(ctrl_q[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign txEn    = ctrl_q[`CTRL_TXEN];
  assign rxEn    = ctrl_q[`CTRL_RXEN];

  // A receive-only group cannot bond: each lane runs on its own recovered clock.
  // The reserved code bonds nothing, so it must not drive the core clock or pointers.
  assign refused = ((reqMode == BOND_X2) || (reqMode == BOND_X4)) && !txEn;
  assign mode    = (refused || (reqMode == BOND_RSVD)) ? BOND_NONE : reqMode;

  // The far PLL is only reachable by a two-lane group in a large package.
  assign farOk = ctrl_q[`CTRL_FAR] && ctrl_q[`CTRL_BIGPKG] && (mode == BOND_X2);

  // One common low-speed path for the whole group, picked from an adjacent PLL, or from pllTickFar when farOk.
  always_comb
  begin
    if (farOk)
      bondLs = pllTickFar;
    else
      bondLs = ctrl_q[`CTRL_BSRC] ? pllTickB : pllTickA;
  end

  // Rate match path only exists with both directions on.
  assign rmPath = ctrl_q[`CTRL_RMATCH] && txEn && rxEn;

  // Avalon slave: one wait cycle, then the answer.
  assign busReq          = avs_read || avs_write;
  assign avs_waitrequest = busReq && !ack_q;
  assign wrTake          = avs_write && ack_q;
  assign avs_readdata    = rdData_q;
  assign ptrRst          = wrTake && (avs_address == `ADDR_CTRL)
                           && avs_writedata[`CTRL_PRST];

  // Handshake state.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= busReq && !ack_q;
  end

  // Register writes; the pointer reset bit is a pulse and is not stored.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      ctrl_q  <= `CTRL_RESET;
      chSel_q <= `CHSEL_RESET;
    end
    else if (wrTake)
    begin
      if (avs_address == `ADDR_CTRL)
        ctrl_q <= {1'b0, avs_writedata[9:0]};
      else if (avs_address == `ADDR_CHSEL)
        chSel_q <= avs_writedata[3:0];
    end
  end

  // Read data is captured in the wait cycle so it stands when waitrequest drops.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      rdData_q <= 32'h0;
    else if (avs_read && !ack_q)
    begin
      unique case (avs_address)
        `ADDR_CTRL:   rdData_q <= {21'h0, ctrl_q};
        `ADDR_CHSEL:  rdData_q <= {28'h0, chSel_q};
        `ADDR_STATUS: rdData_q <= {22'h0, bondRd_q, bondWr_q, farOk, refused, mode};
        default:      rdData_q <= 32'h0;
      endcase
    end
  end

  // Shared halving toggle keeps every bonded lane on the same half phase.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || ptrRst)
      bondHalf_q <= 1'b0;
    else if (bondLs)
      bondHalf_q <= !bondHalf_q;
  end

  // One pointer pair for the group; resetting it in one step keeps lanes aligned.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || ptrRst)
    begin
      bondWr_q <= 3'h0;
      bondRd_q <= 3'h0;
    end
    else if (mode != BOND_NONE)
    begin
      if (bondLs)
        bondWr_q <= bondWr_q + 3'h1;
      if (|bondTx)
        bondRd_q <= bondRd_q + 3'h1;
    end
  end

  // The group clock leaves the block as the core clock for fabric logic.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      coreClkOut <= 1'b0;
    else
      coreClkOut <= (mode != BOND_NONE) && bondLs;
  end

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1)
    begin : g_lane
      logic       bonded;
      logic       ownLs;
      logic       ls;
      logic       half;
      logic       ownHalf_q;
      logic       rxHalf_q;
      logic       txRd;
      logic [2:0] wr_q;
      logic [2:0] rd_q;

      // Lanes outside the group keep their own independent clocking.
      assign bonded = inGroup(mode, ch);
      assign ownLs  = chSel_q[ch] ? pllTickB : pllTickA;
      assign ls     = bonded ? bondLs : ownLs;
      assign half   = bonded ? bondHalf_q : ownHalf_q;
      assign txRd   = txEn && ls && (!ctrl_q[`CTRL_BSER] || half);
      assign bondTx[ch] = bonded && txRd;

      // Private halving toggles for an unbonded lane and for the recovered clock.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          ownHalf_q <= 1'b0;
          rxHalf_q  <= 1'b0;
        end
        else
        begin
          if (ownLs)
            ownHalf_q <= !ownHalf_q;
          if (cdrLsTick[ch])
            rxHalf_q <= !rxHalf_q;
        end
      end

      // Private pointers, used only while the lane is not bonded.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          wr_q <= 3'h0;
          rd_q <= 3'h0;
        end
        else if (!bonded)
        begin
          if (ownLs)
            wr_q <= wr_q + 3'h1;
          if (txRd)
            rd_q <= rd_q + 3'h1;
        end
      end

      // Transmit side clocks.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          hsClkEn[ch]    <= 1'b0;
          txPcsEn[ch]    <= 1'b0;
          txFifoRdEn[ch] <= 1'b0;
        end
        else
        begin
          // Each lane picks its own fast PLL inside a group, except that a group on the far PLL takes pllTickFar.
          hsClkEn[ch]    <= (bonded && farOk) ? pllTickFar
                            : (chSel_q[ch] ? pllTickB : pllTickA);
          txPcsEn[ch]    <= txEn && ls;
          txFifoRdEn[ch] <= txRd;
        end
      end

      // Receive side clocks: with rate match, its read side onward uses the lane's low-speed clock,
      // otherwise everything after the aligner runs on the recovered clock.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          deserEn[ch]    <= 1'b0;
          alignEn[ch]    <= 1'b0;
          rmWrEn[ch]     <= 1'b0;
          rmRdEn[ch]     <= 1'b0;
          rxPcsEn[ch]    <= 1'b0;
          rxFifoWrEn[ch] <= 1'b0;
          rxClkOut[ch]   <= 1'b0;
        end
        else
        begin
          deserEn[ch] <= rxEn && cdrHsTick[ch];
          alignEn[ch] <= rxEn && cdrLsTick[ch];
          if (rmPath)
          begin
            rmWrEn[ch]     <= cdrLsTick[ch];
            rmRdEn[ch]     <= ls;
            rxPcsEn[ch]    <= ls;
            rxFifoWrEn[ch] <= ls && (!ctrl_q[`CTRL_BDES] || half);
            rxClkOut[ch]   <= 1'b0;
          end
          else
          begin
            rmWrEn[ch]     <= 1'b0;
            rmRdEn[ch]     <= 1'b0;
            rxPcsEn[ch]    <= rxEn && cdrLsTick[ch];
            rxFifoWrEn[ch] <= rxEn && cdrLsTick[ch]
                              && (!ctrl_q[`CTRL_BDES] || rxHalf_q);
            rxClkOut[ch]   <= rxEn && cdrLsTick[ch];
          end
        end
      end

      // Bonded lanes show the shared pointers, so their latency is identical.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b)
        begin
          fifoWrPtr[3*ch +: 3] <= 3'h0;
          fifoRdPtr[3*ch +: 3] <= 3'h0;
        end
        else
        begin
          fifoWrPtr[3*ch +: 3] <= bonded ? bondWr_q : wr_q;
          fifoRdPtr[3*ch +: 3] <= bonded ? bondRd_q : rd_q;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### testbench/bonded_lane_clock_distribution_test.sv
// Purpose: Directed test of the bonded lane clock router.
// Assumes: Routed outputs appear one cycle after their ticks.
// Notes: Waitrequest is sampled at the rising edge that completes the transfer.
`include "bond_clk_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bonded_lane_clock_distribution_test;
  logic sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic pllTickA = 1'b0, pllTickB = 1'b0, pllTickFar = 1'b0, avs_waitrequest, coreClkOut;
  logic [3:0] avs_address = 4'h0, cdrHsTick = 4'h0, cdrLsTick = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] hsClkEn, txPcsEn, txFifoRdEn, deserEn, alignEn, rmWrEn, rmRdEn;
  logic [3:0] rxPcsEn, rxFifoWrEn, rxClkOut;
  logic [11:0] fifoWrPtr, fifoRdPtr;
  logic [7:0] beatCnt;
  int miscompares = 0, n_compared = 0, cyc = 0;
  bonded_lane_clock_distribution i_bonded_lane_clock_distribution (.sys_clk, .rst_b,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .pllTickA, .pllTickB, .pllTickFar, .cdrHsTick, .cdrLsTick, .hsClkEn, .txPcsEn, .txFifoRdEn,
    .deserEn, .alignEn, .rmWrEn, .rmRdEn, .rxPcsEn, .rxFifoWrEn, .rxClkOut, .coreClkOut,
    .fifoWrPtr, .fifoRdPtr);
  fabric_sink i_fabric_sink (.sys_clk, .rst_b, .coreClkOut, .beatCnt);
  always #50 sys_clk = ~sys_clk;
  // A hang is cut short long after the directed run should end.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      miscompares++;
      close_out;
    end
  end
  task automatic close_out;
    $display("compared=%0d mismatches=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // One-cycle ticks, then a look at the registered response.
  task automatic pulse(input logic [2:0] pll, input logic [3:0] hs, input logic [3:0] ls);
    @(posedge sys_clk);
    {pllTickA, pllTickB, pllTickFar} <= pll;
    cdrHsTick <= hs;
    cdrLsTick <= ls;
    @(posedge sys_clk);
    {pllTickA, pllTickB, pllTickFar} <= 3'h0;
    cdrHsTick <= 4'h0;
    cdrLsTick <= 4'h0;
    #1;
  endtask
  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, `ADDR_CTRL, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, `ADDR_CHSEL, 32'h0000000C, q);
    bus(1'b0, `ADDR_CHSEL, 32'h0, q);
    chk(q, 32'h0000000C);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task automatic t_x4;
    logic [31:0] q;
    bus(1'b1, `ADDR_CTRL, 32'h00000122, q);
    pulse(3'h4, 4'h0, 4'h0);
    chk({txPcsEn, txFifoRdEn, 3'h0, coreClkOut}, 12'hF01);
    pulse(3'h4, 4'h0, 4'h0);
    chk({txFifoRdEn, beatCnt}, 12'hF01);
    bus(1'b0, `ADDR_STATUS, 32'h0, q);
    chk(q, 32'h000000A2);
    chk({fifoWrPtr, fifoRdPtr}, 24'h492249);
    bus(1'b1, `ADDR_CTRL, 32'h00000522, q);
    bus(1'b0, `ADDR_STATUS, 32'h0, q);
    chk(q, 32'h00000002);
    chk(fifoWrPtr, 12'h000);
  endtask
  task automatic t_x2;
    logic [31:0] q;
    bus(1'b1, `ADDR_CTRL, 32'h00000021, q);
    pulse(3'h2, 4'h0, 4'h0);
    chk({hsClkEn, txPcsEn, 3'h0, coreClkOut}, 12'hCC0);
    pulse(3'h4, 4'h0, 4'h0);
    chk({hsClkEn, txPcsEn, 3'h0, coreClkOut}, 12'h331);
    bus(1'b1, `ADDR_CTRL, 32'h00000039, q);
    pulse(3'h1, 4'h0, 4'h0);
    chk({hsClkEn[1:0], coreClkOut}, 3'h7);
    bus(1'b0, `ADDR_STATUS, 32'h0, q);
    chk(q[3:0], 4'h9);
    bus(1'b1, `ADDR_CTRL, 32'h00000025, q);
    pulse(3'h2, 4'h0, 4'h0);
    chk({txPcsEn, coreClkOut}, 5'h1F);
    bus(1'b1, `ADDR_CTRL, 32'h00000023, q);
    pulse(3'h4, 4'h0, 4'h0);
    chk({txPcsEn, coreClkOut}, 5'h06);
    bus(1'b0, `ADDR_STATUS, 32'h0, q);
    chk(q[2:0], 3'h0);
    bus(1'b1, `ADDR_CTRL, 32'h00000042, q);
    pulse(3'h4, 4'h0, 4'h0);
    chk({txPcsEn, coreClkOut}, 5'h00);
    bus(1'b0, `ADDR_STATUS, 32'h0, q);
    chk(q[2:0], 3'h4);
  endtask
  task automatic t_rx;
    logic [31:0] q;
    bus(1'b1, `ADDR_CTRL, 32'h000000E2, q);
    pulse(3'h0, 4'h5, 4'hF);
    chk({deserEn, alignEn, rmWrEn, rxPcsEn, rxClkOut}, 20'h5FF00);
    pulse(3'h4, 4'h0, 4'h0);
    chk({rmRdEn, rxPcsEn, rxFifoWrEn}, 12'hFFF);
    bus(1'b1, `ADDR_CTRL, 32'h000006E2, q);
    pulse(3'h4, 4'h0, 4'h0);
    chk(rxFifoWrEn, 4'h0);
    pulse(3'h4, 4'h0, 4'h0);
    chk(rxFifoWrEn, 4'hF);
    bus(1'b1, `ADDR_CTRL, 32'h00000062, q);
    pulse(3'h0, 4'h0, 4'hF);
    chk({rxPcsEn, rxFifoWrEn, rxClkOut, 3'h0, coreClkOut}, 16'hFFF0);
  endtask
  // Reset, then the scenarios in a fixed order.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_x4;
    t_x2;
    t_rx;
    repeat (4) @(posedge sys_clk);
    close_out;
  end
endmodule
`default_nettype wire

// ### testbench/fabric_sink.sv
// Purpose: Fabric logic that moves one beat per core clock.
// Assumes: Core clock is a one-cycle enable.
// Notes: Beat count wraps at 256.
`timescale 1ns/1ps
`default_nettype none
module fabric_sink (
  input wire logic  sys_clk,
  input wire logic  rst_b,
  input wire logic  coreClkOut,
  output logic [7:0] beatCnt
);
  // The beat count rides the bonded core clock, never a lane clock.
  always_ff @(posedge sys_clk)
    if (!rst_b) beatCnt <= 8'h00; else if (coreClkOut) beatCnt <= beatCnt + 8'h01;
endmodule
`default_nettype wire

// ### testbench/lane_clk_monitor.sv
// Purpose: Port checks of the bonded lane clock router.
// Assumes: Control word shadowed from accepted writes.
// Notes: Routed pulses lag their tick by one cycle.
`include "bond_clk_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lane_clk_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        pllTickA,
  input wire logic        pllTickB,
  input wire logic        pllTickFar,
  input wire logic [3:0]  cdrHsTick,
  input wire logic [3:0]  cdrLsTick,
  input wire logic [3:0]  txPcsEn,
  input wire logic [3:0]  txFifoRdEn,
  input wire logic [3:0]  deserEn,
  input wire logic [3:0]  alignEn,
  input wire logic [3:0]  rmRdEn,
  input wire logic [3:0]  rxClkOut,
  input wire logic        coreClkOut,
  input wire logic [11:0] fifoWrPtr,
  input wire logic [11:0] fifoRdPtr
);
  logic [9:0] cfg_q;
  logic       odd_q;
  logic       ctrlWr;
  logic       ptrClr;
  logic       bondOk;
  logic       x4On;
  logic       rmOn;

  // A write counts only at the edge where the slave lets it through.
  assign ctrlWr = avs_write && !avs_waitrequest && (avs_address == `ADDR_CTRL);
  assign ptrClr = ctrlWr && avs_writedata[`CTRL_PRST];
  assign bondOk = ((cfg_q[1:0] == 2'h1) || (cfg_q[1:0] == 2'h2)) && cfg_q[5];
  assign x4On   = (cfg_q[1:0] == 2'h2) && cfg_q[5];
  assign rmOn   = cfg_q[7] && cfg_q[6] && cfg_q[5];

  // Shadow of the control word, as the slave stores it.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      cfg_q <= 10'h000;
    else if (ctrlWr)
      cfg_q <= avs_writedata[9:0];
  end

  // Parity of core clock beats; a pointer reset restarts the halving phase.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || ptrClr)
      odd_q <= 1'b0;
    else if (coreClkOut)
      odd_q <= !odd_q;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_WAIT_ONE:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  AST_CORE_SRC:
    assert property (coreClkOut |-> $past(bondOk && (pllTickA || pllTickB || pllTickFar)))
    else $error("core clock beat without a bonded tick");
  AST_COMMON_TX:
    assert property ($past(x4On && (cfg_q[2] ? pllTickB : pllTickA))
                     |-> coreClkOut && (txPcsEn == 4'hF))
    else $error("common clock missed a bonded lane");
  AST_HALF_TX:
    assert property (txFifoRdEn[0] && $past(x4On && cfg_q[8]) |-> coreClkOut && odd_q)
    else $error("transmit FIFO read not halved");
  AST_PTR_SHARE:
    assert property (x4On && $past(x4On)
                     |-> (fifoWrPtr == {4{fifoWrPtr[2:0]}})
                         && (fifoRdPtr == {4{fifoRdPtr[2:0]}}))
    else $error("bonded pointers differ");
  AST_DESER:
    assert property (deserEn == ($past(cdrHsTick) & {4{$past(cfg_q[6])}}))
    else $error("deserializer enable wrong");
  AST_ALIGN:
    assert property (alignEn == ($past(cdrLsTick) & {4{$past(cfg_q[6])}}))
    else $error("aligner enable wrong");
  AST_RM_READ:
    assert property (rmRdEn[0] && $past(bondOk) |-> coreClkOut)
    else $error("rate match read off the common clock");
  AST_RXCLK:
    assert property (rxClkOut == ($past(cdrLsTick) & {4{$past(cfg_q[6] && !rmOn)}}))
    else $error("recovered clock output wrong");
endmodule
bind bonded_lane_clock_distribution lane_clk_monitor i_lane_clk_monitor (.sys_clk, .rst_b,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .pllTickA, .pllTickB,
  .pllTickFar, .cdrHsTick, .cdrLsTick, .txPcsEn, .txFifoRdEn, .deserEn, .alignEn, .rmRdEn,
  .rxClkOut, .coreClkOut, .fifoWrPtr, .fifoRdPtr);
`default_nettype wire
